/* pkg/awgmt_pkg.sv */
// constants, register map and carrier types of the marker and trigger output block
package awgmt_pkg;
    // sample word layout
    localparam int ANA_W  = 14;
    localparam int MRK_W  = 2;
    localparam int TRIG_N = 4;
    localparam logic [ANA_W-1:0] ANA_MAX = 14'h1fff;
    localparam logic [ANA_W-1:0] ANA_MIN = 14'h2000;
    // timing: sequencer tick and samples carried per tick
    localparam int CLK_PERIOD_PS    = 5000;
    localparam int SEQ_PERIOD_PS    = 4000;
    localparam int SAMPLE_PERIOD_PS = 500;
    localparam int SPT          = SEQ_PERIOD_PS / SAMPLE_PERIOD_PS;
    localparam int LANE_W       = $clog2(SPT);
    localparam int SEQ_TICK_RAW = (SEQ_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SEQ_TICK_CYC = (SEQ_TICK_RAW < 1) ? 1 : SEQ_TICK_RAW;
    localparam int TICK_W       = $clog2(SEQ_TICK_CYC + 1);
    // waveform store and queues
    localparam int ROWS    = 8;
    localparam int ROW_W   = $clog2(ROWS);
    localparam int WADDR_W = ROW_W + LANE_W;
    localparam int Q_DEPTH = 4;
    localparam int QCNT_W  = $clog2(Q_DEPTH + 1);
    // marker connectors and source select
    localparam int NCONN        = 2;
    localparam int SRC_W        = 3;
    localparam int SRC_TRIG_BIT = 2;
    // apb register byte offsets
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_CPUSH  = 8'h08;
    localparam logic [7:0] OFF_PPUSH  = 8'h0c;
    localparam logic [7:0] OFF_WADDR  = 8'h10;
    localparam logic [7:0] OFF_WDATA  = 8'h14;
    localparam logic [7:0] OFF_MSRC   = 8'h18;

    typedef struct packed {
        logic [MRK_W-1:0] mark;
        logic [ANA_W-1:0] value;
    } awgmt_sample_t;

    typedef struct packed {
        logic [MRK_W-1:0] cfg;
        logic [1:0]       pad;
        logic [ANA_W-1:0] value;
    } awgmt_wwr_t;

    typedef struct packed {
        logic              wait_op;
        logic [TRIG_N-1:0] bits;
    } awgmt_cinstr_t;

    typedef struct packed {
        logic [ROW_W-1:0] add_row;
        logic             add;
        logic             zero;
        logic [ROW_W-1:0] nrows_m1;
        logic [ROW_W-1:0] start;
    } awgmt_pinstr_t;

    typedef struct packed {
        logic [QCNT_W-1:0] pq_cnt;
        logic [QCNT_W-1:0] cq_cnt;
        logic              busy;
        logic [TRIG_N-1:0] trig;
    } awgmt_status_t;

    localparam int CI_W = $bits(awgmt_cinstr_t);
    localparam int PI_W = $bits(awgmt_pinstr_t);
    localparam int WW_W = $bits(awgmt_wwr_t);
endpackage : awgmt_pkg

/* logic/awgmt_queue.sv */
// flip-flop instruction queue with valid/ready on both sides
`timescale 1ns/1ps
module awgmt_queue #(
    parameter int W     = awgmt_pkg::CI_W,
    parameter int DEPTH = awgmt_pkg::Q_DEPTH
) (
    // clock and reset
    input  wire logic                       sys_clk_i,
    input  wire logic                       rstn_i,
    // fill side
    input  wire logic                       in_valid_i,
    input  wire logic [W-1:0]               in_data_i,
    output wire logic                       in_ready_o,
    // drain side
    output wire logic                       out_valid_o,
    output wire logic [W-1:0]               out_data_o,
    input  wire logic                       out_ready_i,
    output wire logic [$clog2(DEPTH+1)-1:0] count_o
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0]  mem_q [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0]   cnt_q;

    // handshakes; depth is a power of two so pointers wrap naturally
    wire do_w = in_valid_i & in_ready_o;
    wire do_r = out_valid_o & out_ready_i;
    assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o  = mem_q[rp_q];
    assign count_o     = cnt_q;

    // pointers; reset empties the queue
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            wp_q  <= wp_q + AW'(do_w);
            rp_q  <= rp_q + AW'(do_r);
            cnt_q <= cnt_q + (AW+1)'(do_w) - (AW+1)'(do_r);
        end
    end

    // storage needs no reset, the count guards it
    always_ff @(posedge sys_clk_i) begin
        if (do_w) begin
            mem_q[wp_q] <= in_data_i;
        end
    end
endmodule : awgmt_queue

/* logic/awgmt_mark_mux.sv */
// source select and output register of one marker connector
`timescale 1ns/1ps
module awgmt_mark_mux (
    // clock, reset and sequencer tick
    input  wire logic                                       sys_clk_i,
    input  wire logic                                       rstn_i,
    input  wire logic                                       tick_i,
    // source select and candidates
    input  wire logic [awgmt_pkg::SRC_W-1:0]                sel_i,
    input  wire logic [awgmt_pkg::MRK_W-1:0][awgmt_pkg::SPT-1:0] mk_lane_i,
    input  wire logic [awgmt_pkg::TRIG_N-1:0]               trig_i,
    // connector samples, lane 0 first in time
    output logic      [awgmt_pkg::SPT-1:0]                  pin_o
);
    // trigger bits only move per tick, so they fill all lanes alike
    wire                         is_trig = sel_i[awgmt_pkg::SRC_TRIG_BIT];
    wire [1:0]                   tidx    = sel_i[1:0];
    wire [awgmt_pkg::SPT-1:0]    pick    = is_trig ? {awgmt_pkg::SPT{trig_i[tidx]}}
                                                   : mk_lane_i[sel_i[0]];

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            pin_o <= '0;
        end else if (tick_i) begin
            pin_o <= pick;
        end
    end
endmodule : awgmt_mark_mux

/* logic/awgmt_core.sv */
// marker and trigger output core: apb registers, queues, playback and trigger state
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module awgmt_core (
    // clock and reset
    input  wire logic                              sys_clk_i,
    input  wire logic                              rstn_i,
    // apb slave
    input  wire logic                              psel_i,
    input  wire logic                              penable_i,
    input  wire logic                              pwrite_i,
    input  wire logic [7:0]                        paddr_i,
    input  wire logic [31:0]                       pwdata_i,
    output logic      [31:0]                       prdata_o,
    output wire logic                              pready_o,
    output wire logic                              pslverr_o,
    // analog samples, lane 0 first in time
    output logic      [awgmt_pkg::SPT-1:0][awgmt_pkg::ANA_W-1:0] analog_o,
    // marker connectors and trigger outputs
    output wire logic [awgmt_pkg::NCONN-1:0][awgmt_pkg::SPT-1:0] mark_pin_o,
    output logic      [awgmt_pkg::TRIG_N-1:0]      trig_o
);
    // sample arithmetic shared by every lane
    function automatic logic [awgmt_pkg::MRK_W-1:0] mk_decode(
        input logic [awgmt_pkg::MRK_W-1:0] cfg);
        mk_decode[0] = (cfg == 2'h1) || (cfg == 2'h3);
        mk_decode[1] = (cfg == 2'h2) || (cfg == 2'h3);
    endfunction : mk_decode

    function automatic awgmt_pkg::awgmt_sample_t smp_sum(
        input awgmt_pkg::awgmt_sample_t a,
        input awgmt_pkg::awgmt_sample_t b);
        logic signed [awgmt_pkg::ANA_W:0] s;
        s = $signed({a.value[awgmt_pkg::ANA_W-1], a.value})
          + $signed({b.value[awgmt_pkg::ANA_W-1], b.value});
        smp_sum.mark = a.mark | b.mark;
        if (s[awgmt_pkg::ANA_W] != s[awgmt_pkg::ANA_W-1]) begin
            smp_sum.value = s[awgmt_pkg::ANA_W] ? awgmt_pkg::ANA_MIN : awgmt_pkg::ANA_MAX;
        end else begin
            smp_sum.value = s[awgmt_pkg::ANA_W-1:0];
        end
    endfunction : smp_sum

    // state
    logic                                   run_q;
    logic [awgmt_pkg::TICK_W-1:0]           tcnt_q;
    logic [awgmt_pkg::WADDR_W-1:0]          waddr_q;
    awgmt_pkg::awgmt_sample_t               wave_mem_q [awgmt_pkg::ROWS*awgmt_pkg::SPT];
    logic [awgmt_pkg::NCONN-1:0][awgmt_pkg::SRC_W-1:0] msrc_q;
    logic [awgmt_pkg::TRIG_N-1:0]           trig_q;
    logic                                   act_q;
    awgmt_pkg::awgmt_pinstr_t               cur_q;
    logic [awgmt_pkg::ROW_W-1:0]            row_q;
    logic [awgmt_pkg::ROW_W-1:0]            row2_q;
    logic [awgmt_pkg::ROW_W-1:0]            left_q;
    logic                                   err_q;
    awgmt_pkg::awgmt_sample_t               smp_d [awgmt_pkg::SPT];
    logic [awgmt_pkg::MRK_W-1:0][awgmt_pkg::SPT-1:0] mk_lane;

    // sequencer tick divider; one clock covers a whole 4 ns tick here
    wire tick = (tcnt_q == awgmt_pkg::TICK_W'(awgmt_pkg::SEQ_TICK_CYC - 1));
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i || tick) begin
            tcnt_q <= '0;
        end else begin
            tcnt_q <= tcnt_q + 1'b1;
        end
    end

    // apb decode; every transfer ends in its first access cycle
    wire setup     = psel_i & ~penable_i;
    wire wr_acc    = psel_i & penable_i & pwrite_i & ~err_q;
    wire hit_ctrl  = (paddr_i == awgmt_pkg::OFF_CTRL);
    wire hit_stat  = (paddr_i == awgmt_pkg::OFF_STATUS);
    wire hit_cpush = (paddr_i == awgmt_pkg::OFF_CPUSH);
    wire hit_ppush = (paddr_i == awgmt_pkg::OFF_PPUSH);
    wire hit_waddr = (paddr_i == awgmt_pkg::OFF_WADDR);
    wire hit_wdata = (paddr_i == awgmt_pkg::OFF_WDATA);
    wire hit_msrc  = (paddr_i == awgmt_pkg::OFF_MSRC);
    wire mapped    = hit_ctrl | hit_stat | hit_cpush | hit_ppush
                   | hit_waddr | hit_wdata | hit_msrc;
    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i & penable_i & err_q;

    // queue wiring
    wire                           cq_rdy;
    wire                           cq_vld;
    wire                           cq_pop;
    wire [awgmt_pkg::CI_W-1:0]     cq_raw;
    wire [awgmt_pkg::QCNT_W-1:0]   cq_cnt;
    wire                           pq_rdy;
    wire                           pq_vld;
    wire                           pq_pop;
    wire [awgmt_pkg::PI_W-1:0]     pq_raw;
    wire [awgmt_pkg::QCNT_W-1:0]   pq_cnt;
    awgmt_pkg::awgmt_cinstr_t      cq_head;
    awgmt_pkg::awgmt_pinstr_t      pq_head;
    assign cq_head = cq_raw;
    assign pq_head = pq_raw;

    // a push into a full queue is refused with an error
    wire push_full = (hit_cpush & ~cq_rdy) | (hit_ppush & ~pq_rdy);

    // read data selection
    awgmt_pkg::awgmt_status_t status;
    assign status = '{pq_cnt: pq_cnt, cq_cnt: cq_cnt, busy: act_q, trig: trig_q};
    wire [31:0] rd_mux = hit_ctrl  ? 32'(run_q)   :
                         hit_stat  ? 32'(status)  :
                         hit_waddr ? 32'(waddr_q) :
                         hit_msrc  ? 32'(msrc_q)  : 32'h0000_0000;

    // answer is latched in setup so that prdata comes from a flip-flop
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            prdata_o <= '0;
            err_q    <= 1'b0;
        end else if (setup) begin
            prdata_o <= pwrite_i ? 32'h0000_0000 : rd_mux;
            err_q    <= ~mapped | (pwrite_i & push_full);
        end
    end

    // control and source registers
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            run_q  <= 1'b0;
            msrc_q <= '0;
        end else begin
            if (wr_acc && hit_ctrl) begin
                run_q <= pwdata_i[0];
            end
            if (wr_acc && hit_msrc) begin
                msrc_q <= pwdata_i[awgmt_pkg::NCONN*awgmt_pkg::SRC_W-1:0];
            end
        end
    end

    // waveform store: one sample per data write, address steps on its own
    awgmt_pkg::awgmt_wwr_t ww;
    assign ww = pwdata_i[awgmt_pkg::WW_W-1:0];
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            waddr_q <= '0;
            for (int i = 0; i < awgmt_pkg::ROWS*awgmt_pkg::SPT; i++) begin
                wave_mem_q[i] <= '0;
            end
        end else if (wr_acc && hit_waddr) begin
            waddr_q <= pwdata_i[awgmt_pkg::WADDR_W-1:0];
        end else if (wr_acc && hit_wdata) begin
            wave_mem_q[waddr_q] <= '{mark: mk_decode(ww.cfg), value: ww.value};
            waddr_q             <= waddr_q + 1'b1;
        end
    end

    // instruction queues, emptied by reset
    awgmt_queue #(.W(awgmt_pkg::CI_W), .DEPTH(awgmt_pkg::Q_DEPTH)) u_cq (
        .sys_clk_i   (sys_clk_i),
        .rstn_i      (rstn_i),
        .in_valid_i  (wr_acc & hit_cpush),
        .in_data_i   (pwdata_i[awgmt_pkg::CI_W-1:0]),
        .in_ready_o  (cq_rdy),
        .out_valid_o (cq_vld),
        .out_data_o  (cq_raw),
        .out_ready_i (cq_pop),
        .count_o     (cq_cnt)
    );
    awgmt_queue #(.W(awgmt_pkg::PI_W), .DEPTH(awgmt_pkg::Q_DEPTH)) u_pq (
        .sys_clk_i   (sys_clk_i),
        .rstn_i      (rstn_i),
        .in_valid_i  (wr_acc & hit_ppush),
        .in_data_i   (pwdata_i[awgmt_pkg::PI_W-1:0]),
        .in_ready_o  (pq_rdy),
        .out_valid_o (pq_vld),
        .out_data_o  (pq_raw),
        .out_ready_i (pq_pop),
        .count_o     (pq_cnt)
    );

    // control queue: one instruction per tick, a wait holds while playback is busy
    wire play_busy = act_q | pq_vld;
    wire c_go      = tick & run_q & cq_vld;
    assign cq_pop  = c_go & (~cq_head.wait_op | ~play_busy);
    wire set_ex    = cq_pop & ~cq_head.wait_op;
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            trig_q <= '0;
        end else if (set_ex) begin
            trig_q <= cq_head.bits;
        end
    end

    // playback engine; the next entry loads in the tick the last row is sent
    wire row_end  = act_q & (left_q == '0);
    assign pq_pop = tick & run_q & pq_vld & (~act_q | row_end);
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            act_q  <= 1'b0;
            cur_q  <= '0;
            row_q  <= '0;
            row2_q <= '0;
            left_q <= '0;
        end else if (tick) begin
            if (pq_pop) begin
                act_q  <= 1'b1;
                cur_q  <= pq_head;
                row_q  <= pq_head.start;
                row2_q <= pq_head.add_row;
                left_q <= pq_head.nrows_m1;
            end else if (row_end) begin
                act_q <= 1'b0;
            end else if (act_q) begin
                row_q  <= row_q + 1'b1;
                row2_q <= row2_q + 1'b1;
                left_q <= left_q - 1'b1;
            end
        end
    end

    // per-lane sample of this tick; idle and zero-play give all-zero words
    always_comb begin
        for (int l = 0; l < awgmt_pkg::SPT; l++) begin
            if (!act_q || cur_q.zero) begin
                smp_d[l] = '0;
            end else if (cur_q.add) begin
                smp_d[l] = smp_sum(wave_mem_q[{row_q, awgmt_pkg::LANE_W'(l)}],
                                   wave_mem_q[{row2_q, awgmt_pkg::LANE_W'(l)}]);
            end else begin
                smp_d[l] = wave_mem_q[{row_q, awgmt_pkg::LANE_W'(l)}];
            end
            for (int m = 0; m < awgmt_pkg::MRK_W; m++) begin
                mk_lane[m][l] = smp_d[l].mark[m];
            end
        end
    end

    // output stage: analog, markers and triggers leave on the same edge
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            analog_o <= '0;
            trig_o   <= '0;
        end else if (tick) begin
            for (int l = 0; l < awgmt_pkg::SPT; l++) begin
                analog_o[l] <= smp_d[l].value;
            end
            trig_o <= trig_q;
        end
    end

    // one source selector per marker connector
    for (genvar c = 0; c < awgmt_pkg::NCONN; c++) begin : g_conn
        awgmt_mark_mux u_mux (
            .sys_clk_i (sys_clk_i),
            .rstn_i    (rstn_i),
            .tick_i    (tick),
            .sel_i     (msrc_q[c]),
            .mk_lane_i (mk_lane),
            .trig_i    (trig_q),
            .pin_o     (mark_pin_o[c])
        );
    end

    // checks on the block's own behaviour
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rstn_i);

    property p_rst_clear;
        @(posedge sys_clk_i) disable iff (1'b0)
        !rstn_i |=> (trig_o == '0) && (mark_pin_o == '0) && (analog_o == '0)
                    && (cq_cnt == '0) && (pq_cnt == '0);
    endproperty
    a_rst_clear: assert property (p_rst_clear) else $error("reset left outputs set");

    property p_set_trig;
        set_ex |=> trig_q == $past(cq_head.bits) ##1 trig_o == $past(cq_head.bits, 2);
    endproperty
    a_set_trig: assert property (p_set_trig) else $error("trigger bits not applied");

    property p_trig_hold;
        !set_ex |=> $stable(trig_q);
    endproperty
    a_trig_hold: assert property (p_trig_hold) else $error("trigger state moved");

    property p_wait_stall;
        (cq_vld && cq_head.wait_op && play_busy) |-> !cq_pop;
    endproperty
    a_wait_stall: assert property (p_wait_stall) else $error("wait passed busy playback");

    property p_wait_go;
        (tick && run_q && cq_vld && cq_head.wait_op && !play_busy) |-> cq_pop;
    endproperty
    a_wait_go: assert property (p_wait_go) else $error("wait stuck after playback");

    property p_no_gap;
        (tick && run_q && row_end && pq_vld) |=> act_q && (row_q == $past(pq_head.start));
    endproperty
    a_no_gap: assert property (p_no_gap) else $error("gap between playback entries");

    property p_idle_zero;
        (tick && !act_q) |=> (analog_o == '0)
            && ($past(msrc_q[0][awgmt_pkg::SRC_TRIG_BIT]) || (mark_pin_o[0] == '0));
    endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("markers not zero when idle");

    property p_align;
        (tick && !msrc_q[0][awgmt_pkg::SRC_TRIG_BIT] && act_q && !cur_q.zero && !cur_q.add)
        |=> mark_pin_o[0] == $past(mk_lane[msrc_q[0][0]])
            && analog_o[0] == $past(wave_mem_q[{row_q, awgmt_pkg::LANE_W'(0)}].value);
    endproperty
    a_align: assert property (p_align) else $error("marker lanes out of step");

    property p_or_merge;
        (act_q && cur_q.add && !cur_q.zero) |-> smp_d[0].mark
            == (wave_mem_q[{row_q, awgmt_pkg::LANE_W'(0)}].mark
              | wave_mem_q[{row2_q, awgmt_pkg::LANE_W'(0)}].mark);
    endproperty
    a_or_merge: assert property (p_or_merge) else $error("marker merge is not an or");

    property p_decode;
        (wr_acc && hit_wdata && ww.cfg == 2'h2) |=> wave_mem_q[$past(waddr_q)].mark == 2'h2;
    endproperty
    a_decode: assert property (p_decode) else $error("marker code 2 decoded wrong");

    property p_edge_at_start;
        (set_ex && pq_pop && !act_q) |=> act_q ##1 (trig_o == $past(cq_head.bits, 2));
    endproperty
    a_edge_at_start: assert property (p_edge_at_start) else $error("trigger not at start");

    c_back_to_back: cover property (tick && row_end && pq_pop);
    c_wait_release: cover property (cq_vld && cq_head.wait_op && play_busy ##[1:200] cq_pop);
    c_sum_play: cover property (act_q && cur_q.add);
    c_trig_source: cover property (msrc_q[0][awgmt_pkg::SRC_TRIG_BIT] && set_ex);
endmodule : awgmt_core

/* verification/awgmt_rx_model.sv */
// receiving equipment model: counts rising edges seen on trigger output 0
`timescale 1ns/1ps
module awgmt_rx_model (
    // clock
    input  wire logic                        sys_clk_i,
    // observed outputs of the block
    input  wire logic [awgmt_pkg::TRIG_N-1:0] trig_i,
    // edges seen by the equipment
    output int                               trig_rise_o
);
    logic trig_prev_q = 1'b0;
    // a scope input reacts to the rising edge only, a level that stays high is one event
    always @(posedge sys_clk_i) begin
        if (trig_i[0] === 1'b1 && trig_prev_q !== 1'b1) trig_rise_o <= trig_rise_o + 1;
        trig_prev_q <= trig_i[0];
    end
endmodule : awgmt_rx_model

/* verification/tb_awg_marker_trigger_output.sv */
// self-checking testbench of the marker and trigger output core
`timescale 1ns/1ps
module tb_awg_marker_trigger_output;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er;
    logic [7:0][13:0] analog;
    logic [1:0][7:0] mpin;
    logic [3:0] trig;
    int trig_rise;
    int err_total = 0;
    int tests_run = 0;

    awgmt_core i_awgmt_core (.sys_clk_i(sys_clk), .rstn_i(rstn), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .analog_o(analog),
        .mark_pin_o(mpin), .trig_o(trig));
    awgmt_rx_model i_awgmt_rx_model (.sys_clk_i(sys_clk), .trig_i(trig),
        .trig_rise_o(trig_rise));

    // 5 ns clock
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // one apb transfer; the leading edge keeps transfers apart so no signal is set twice
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // no wait-state count is assumed; only the watchdog ends a stuck access
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : stop_test

    // cut a hang short, the run needs well under a microsecond
    initial begin
        #20000;
        err_total++;
        stop_test;
    end

    initial begin
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        #1;
        chk(trig, 4'h0);
        chk(mpin, 16'h0);
        // row 0 lanes carry codes 0..3, row 1 carries code 1 everywhere, row 2 untouched
        apb(1'b1, 8'h10, 32'h0);
        for (int i = 0; i < 16; i++) begin
            apb(1'b1, 8'h14, (i < 8) ? ((i % 4) << 16) | i : 32'h10000 | (i + 24));
        end
        apb(1'b1, 8'h18, 32'h08);
        apb(1'b1, 8'h08, 32'h01);
        apb(1'b1, 8'h0c, 32'h000);
        apb(1'b1, 8'h08, 32'h10);
        apb(1'b1, 8'h08, 32'h00);
        apb(1'b1, 8'h00, 32'h1);
        repeat (2) @(posedge sys_clk);
        #1;
        chk(trig, 4'h1);
        for (int i = 0; i < 8; i++) begin
            chk(analog[i], i);
            chk(mpin[0][i], i % 2);
            chk(mpin[1][i], (i / 2) % 2);
        end
        @(posedge sys_clk);
        #1;
        chk(mpin, 16'h0);
        chk(trig, 4'h1);
        repeat (4) @(posedge sys_clk);
        #1;
        chk(trig, 4'h0);
        $display("test marker play and wait done");
        // summed play then zero row, with a second set that must not wait
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h08, 32'h03);
        apb(1'b1, 8'h0c, 32'h180);
        apb(1'b1, 8'h0c, 32'h040);
        apb(1'b1, 8'h08, 32'h0c);
        apb(1'b1, 8'h00, 32'h1);
        repeat (2) @(posedge sys_clk);
        #1;
        chk(trig, 4'h3);
        for (int i = 0; i < 8; i++) begin
            chk(analog[i], 32 + 2 * i);
            chk(mpin[0][i], 1'b1);
            chk(mpin[1][i], (i / 2) % 2);
        end
        @(posedge sys_clk);
        #1;
        chk(trig, 4'hc);
        chk(analog, 112'h0);
        chk(mpin, 16'h0);
        $display("test summed play and back to back rows");
        // connector 0 follows trigger bit 0, connector 1 trigger bit 3
        apb(1'b1, 8'h18, 32'h3c);
        repeat (3) @(posedge sys_clk);
        #1;
        chk(mpin, 16'hff00);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h0c);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h1);
        apb(1'b0, 8'h1c, 32'h0);
        chk(er, 1'b1);
        chk(rd, 32'h0);
        chk(trig_rise, 2);
        $display("test source select and registers");
        stop_test;
    end
endmodule : tb_awg_marker_trigger_output
